/* rtl/scfi_pkg.sv */
// scfi_pkg: constants and carriers for the command frame interpreter
// assumes: single clock domain, byte-wide serial receiver/transmitter outside
`default_nettype none
package scfi_pkg;
   // -----------------------------------------------------------------
   // frame layout
   // -----------------------------------------------------------------
   localparam int unsigned SERIAL_FRAME_LEN = 9;   // address + 7 payload + checksum
   localparam int unsigned CAN_FRAME_LEN = 7;      // payload only
   localparam int unsigned VALUE_LEN = 4;          // value bytes, msb first
   localparam logic [3:0] POS_ADDR = 4'h0;
   localparam logic [3:0] POS_CMD = 4'h1;
   localparam logic [3:0] POS_TYPE = 4'h2;
   localparam logic [3:0] POS_BANK = 4'h3;
   localparam logic [3:0] POS_VAL0 = 4'h4;
   localparam logic [3:0] POS_SUM = 4'h8;
   // -----------------------------------------------------------------
   // status codes
   // -----------------------------------------------------------------
   localparam logic [7:0] ST_OK = 8'h64;           // 100 executed
   localparam logic [7:0] ST_STORED = 8'h65;       // 101 loaded to program memory
   localparam logic [7:0] ST_BAD_SUM = 8'h01;
   localparam logic [7:0] ST_BAD_CMD = 8'h02;
   localparam logic [7:0] ST_BAD_TYPE = 8'h03;
   localparam logic [7:0] ST_BAD_VALUE = 8'h04;
   localparam logic [7:0] ST_LOCKED = 8'h05;
   localparam logic [7:0] ST_UNAVAIL = 8'h06;
   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_IDX = 4'h0;
   // -----------------------------------------------------------------
   // carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] kind;
      logic [7:0] bank;
      logic [31:0] value;
   } scfi_cmd_s;
   typedef struct packed {
      logic [7:0] status;
      logic [31:0] value;
   } scfi_res_s;
   typedef enum logic [1:0] {
      SCFI_RECV = 2'b00,
      SCFI_EXEC = 2'b01,
      SCFI_SEND = 2'b11
   } scfi_state_e;
endpackage : scfi_pkg
`default_nettype wire

/* rtl/scfi_sum.sv */
// scfi_sum: running 8-bit modular checksum over a byte stream
// assumes: clear and add never matter in the same cycle except clear+add restarts
`default_nettype none
module scfi_sum (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic add,
   input wire logic [7:0] data,
   output logic [7:0] sum
);
   // -----------------------------------------------------------------
   // accumulator
   // -----------------------------------------------------------------
   // carry past eight bits simply falls away
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sum <= scfi_pkg::RST_BYTE;
      end else if (clear && add) begin
         sum <= data;
      end else if (clear) begin
         sum <= scfi_pkg::RST_BYTE;
      end else if (add) begin
         sum <= sum + data;
      end
   end
endmodule : scfi_sum
`default_nettype wire

/* rtl/scfi_top.sv */
// scfi_top: binary command frame interpreter, receive / execute / reply
// assumes: bytes arrive as one-cycle strobes from a receiver; tx_ready from
// a transmitter; executor answers each command with one done pulse
// Operation
// R1 - transmit only after a full command frame
// R2 - transceiver receives except while replying
// R3 - host waits for reply before next
// R4 - reply only after execution completes
// R5 - payload: command, type, bank, four value
// R6 - serial frame nine bytes, address, checksum
// R7 - order address, cmd, type, bank, value msb-first, sum
// R8 - command checksum is 8-bit sum
// R9 - can frame drops address and checksum
// R10 - exactly one reply per command
// R11 - reply: reply address, module, status, cmd, value, sum
// R12 - reply checksum is 8-bit sum
// R13 - can reply drops address and checksum
// R14 - status 100 executed, 101 stored
// R15 - error codes one through six
// R16 - commands may go to program memory
// R17 - foreign address frames ignored, no reply
`default_nettype none
module scfi_top (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic can_mode,             // 1: seven-byte frames, no address/sum
   input wire logic [7:0] module_addr,
   input wire logic [7:0] reply_addr,
   input wire logic rx_valid,             // one-cycle byte strobe
   input wire logic [7:0] rx_data,
   input wire logic tx_ready,             // transmitter accepts tx byte
   input wire logic exec_done,            // executor finished, pulse
   input wire scfi_pkg::scfi_res_s exec_res, // status and value with done
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_last,                  // final byte of reply
   output logic drive_en,                 // transceiver to transmit
   output logic exec_start,               // pulse: command handed over
   output scfi_pkg::scfi_cmd_s exec_cmd
);
   // -----------------------------------------------------------------
   // state and storage
   // -----------------------------------------------------------------
   scfi_pkg::scfi_state_e state;
   logic [3:0] rx_idx;                    // position within incoming frame
   logic [3:0] tx_idx;                    // position within reply
   logic [7:0] frame_sum;                 // running sum from checksum unit
   logic addr_ok;                         // address byte matched
   logic sum_ok;                          // checksum matched
   logic [7:0] cmd_byte;                  // echoed command number
   scfi_pkg::scfi_res_s res;              // latched result
   logic [3:0] last_rx;                   // index of final received byte
   logic [3:0] last_tx;                   // index of final reply byte
   logic [3:0] pay_pos;                   // serial-relative receive position
   logic frame_end;                       // last byte of command arrives
   logic sum_clear;
   logic sum_add;
   logic [7:0] sum_data;
   logic [7:0] next_tx_data;
   logic [3:0] tx_pos;                    // serial-relative reply position
   logic tx_take;

   assign last_rx = can_mode ? 4'(scfi_pkg::CAN_FRAME_LEN - 1)
                             : 4'(scfi_pkg::SERIAL_FRAME_LEN - 1); // [R6] [R9]
   assign last_tx = last_rx;              // reply mirrors frame length [R13]
   assign pay_pos = can_mode ? rx_idx + 4'h1 : rx_idx;
   assign frame_end = (state == scfi_pkg::SCFI_RECV) && rx_valid && (rx_idx == last_rx);
   // can reply keeps the module address byte and stops before the sum [R13]
   assign tx_pos = can_mode ? tx_idx + 4'h1 : tx_idx;
   assign tx_take = tx_valid && tx_ready;

   // -----------------------------------------------------------------
   // shared checksum unit
   // -----------------------------------------------------------------
   // receive sums bytes before the checksum; send sums reply bytes
   always_comb begin
      sum_clear = 1'b0;
      sum_add = 1'b0;
      sum_data = rx_data;
      if (state == scfi_pkg::SCFI_RECV) begin
         // clear at frame end too, so a refusal reply sums from zero
         sum_clear = (rx_idx == scfi_pkg::RST_IDX) || frame_end;
         sum_add = rx_valid && (pay_pos != scfi_pkg::POS_SUM); // [R8]
      end else if (state == scfi_pkg::SCFI_SEND) begin
         sum_add = tx_take;
         sum_data = tx_data;                // [R12]
      end else begin
         sum_clear = 1'b1;
      end
   end

   scfi_sum u_sum (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clear(sum_clear),
      .add(sum_add),
      .data(sum_data),
      .sum(frame_sum)
   );

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   // recv -> exec -> send; host turn-taking assumed, late bytes dropped [R3]
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= scfi_pkg::SCFI_RECV;
      end else begin
         case (state)
            scfi_pkg::SCFI_RECV: begin
               if (frame_end) begin
                  if (!can_mode && rx_data != frame_sum) begin
                     state <= addr_ok ? scfi_pkg::SCFI_SEND : scfi_pkg::SCFI_RECV; // [R17]
                  end else if (can_mode || addr_ok) begin
                     state <= scfi_pkg::SCFI_EXEC;  // full frame first [R1]
                  end
               end
            end
            scfi_pkg::SCFI_EXEC: begin
               if (exec_done) begin
                  state <= scfi_pkg::SCFI_SEND;     // only after execution [R4]
               end
            end
            scfi_pkg::SCFI_SEND: begin
               if (tx_take && tx_last) begin
                  state <= scfi_pkg::SCFI_RECV;     // one reply then listen [R10]
               end
            end
            default: state <= scfi_pkg::SCFI_RECV;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // frame capture
   // -----------------------------------------------------------------
   // bytes land in fixed fields by position [R5] [R7]
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_idx <= scfi_pkg::RST_IDX;
         addr_ok <= 1'b0;
         cmd_byte <= scfi_pkg::RST_BYTE;
         exec_cmd <= '0;
      end else if (state != scfi_pkg::SCFI_RECV) begin
         rx_idx <= scfi_pkg::RST_IDX;
      end else if (rx_valid) begin
         rx_idx <= (rx_idx == last_rx) ? scfi_pkg::RST_IDX : rx_idx + 4'h1;
         case (pay_pos)
            scfi_pkg::POS_ADDR: addr_ok <= (rx_data == module_addr); // [R17]
            scfi_pkg::POS_CMD: begin
               exec_cmd.cmd <= rx_data;
               cmd_byte <= rx_data;
            end
            scfi_pkg::POS_TYPE: exec_cmd.kind <= rx_data;
            scfi_pkg::POS_BANK: exec_cmd.bank <= rx_data;
            scfi_pkg::POS_SUM: ;
            default: exec_cmd.value <= {exec_cmd.value[23:0], rx_data}; // msb first [R7]
         endcase
      end
   end

   // -----------------------------------------------------------------
   // checksum verdict and executor handshake
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sum_ok <= 1'b1;
         exec_start <= 1'b0;
      end else begin
         exec_start <= 1'b0;
         if (frame_end) begin
            sum_ok <= can_mode || (rx_data == frame_sum);           // [R8]
            exec_start <= can_mode || (addr_ok && rx_data == frame_sum);
         end
      end
   end

   // -----------------------------------------------------------------
   // result latch
   // -----------------------------------------------------------------
   // executor supplies ok, stored-to-program or an error code [R14] [R15] [R16]
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         res <= '0;
      end else if (frame_end && !can_mode && rx_data != frame_sum) begin
         res.status <= scfi_pkg::ST_BAD_SUM;  // mismatch answered only if address matched, not run [R15]
         res.value <= '0;
      end else if (state == scfi_pkg::SCFI_EXEC && exec_done) begin
         res <= exec_res;
      end
   end

   // -----------------------------------------------------------------
   // reply byte select
   // -----------------------------------------------------------------
   always_comb begin
      case (tx_pos)
         4'h0: next_tx_data = reply_addr;                          // [R11]
         4'h1: next_tx_data = module_addr;
         4'h2: next_tx_data = res.status;
         4'h3: next_tx_data = cmd_byte;
         4'h4: next_tx_data = res.value[31:24];
         4'h5: next_tx_data = res.value[23:16];
         4'h6: next_tx_data = res.value[15:8];
         4'h7: next_tx_data = res.value[7:0];
         default: next_tx_data = frame_sum;                        // [R12]
      endcase
   end

   // -----------------------------------------------------------------
   // transmitter
   // -----------------------------------------------------------------
   // one byte presented at a time; sum unit already holds previous bytes
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_idx <= scfi_pkg::RST_IDX;
         tx_valid <= 1'b0;
         tx_data <= scfi_pkg::RST_BYTE;
         tx_last <= 1'b0;
      end else if (state != scfi_pkg::SCFI_SEND) begin
         tx_idx <= scfi_pkg::RST_IDX;
         tx_valid <= 1'b0;
         tx_last <= 1'b0;
      end else if (!tx_valid) begin
         tx_valid <= 1'b1;                                         // [R1]
         tx_data <= next_tx_data;
         tx_last <= (tx_idx == last_tx);
      end else if (tx_take) begin
         tx_valid <= 1'b0;                  // gap lets sum settle
         tx_idx <= tx_idx + 4'h1;
      end
   end

   // -----------------------------------------------------------------
   // bus ownership
   // -----------------------------------------------------------------
   // drive only while the reply is in flight [R2]
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         drive_en <= 1'b0;
      end else begin
         drive_en <= (state == scfi_pkg::SCFI_SEND) && !(tx_take && tx_last);
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   // each property samples registered state one edge after its cause
   tx_needs_frame_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R1]
      $rose(state == scfi_pkg::SCFI_SEND) |-> $past(frame_end) || $past(exec_done))
      else $error("reply started without a received frame");
   idle_no_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R2]
      tx_valid |-> drive_en)
      else $error("byte offered while transceiver receiving");
   // no reply byte and no drive while the executor works
   reply_after_exec_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R4]
      (state == scfi_pkg::SCFI_EXEC) |-> !tx_valid && !drive_en)
      else $error("reply before execution finished");
   bad_sum_code_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R15]
      (frame_end && !can_mode && addr_ok && rx_data != frame_sum)
      |=> res.status == scfi_pkg::ST_BAD_SUM)
      else $error("checksum mismatch not reported as 1");
   foreign_silent_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R17]
      (frame_end && !can_mode && !addr_ok) |=> state == scfi_pkg::SCFI_RECV)
      else $error("foreign frame answered");
   reply_ends_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R10]
      (tx_take && tx_last) |=> state == scfi_pkg::SCFI_RECV && !tx_valid)
      else $error("reply did not end after last byte");
   good_frame_runs_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R8]
      (frame_end && !can_mode && addr_ok && rx_data == frame_sum) |=> exec_start)
      else $error("valid frame not executed");
   sum_byte_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R12]
      (tx_valid && tx_last && !can_mode) |-> tx_data == frame_sum)
      else $error("reply checksum wrong");
   // nothing on the wire while listening
   listen_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R2]
      (state == scfi_pkg::SCFI_RECV) |-> !drive_en && !tx_valid)
      else $error("transceiver busy while listening");
   // hand-over only when entering execution
   start_in_exec_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R4]
      exec_start |-> state == scfi_pkg::SCFI_EXEC)
      else $error("hand-over outside execution");
   // hand-over pulse lasts one cycle
   start_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R10]
      exec_start |=> !exec_start)
      else $error("hand-over longer than one cycle");
   // only frames with a good sum are executed
   exec_sum_ok_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R8]
      (state == scfi_pkg::SCFI_EXEC) |-> sum_ok)
      else $error("frame with bad sum executed");
   // bytes arriving while busy are dropped, not counted
   busy_drops_bytes_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R3]
      (state != scfi_pkg::SCFI_RECV) |-> rx_idx == scfi_pkg::RST_IDX)
      else $error("byte counted while busy");
   // reply sum starts from zero on every path into send
   reply_sum_fresh_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R12]
      $rose(state == scfi_pkg::SCFI_SEND) |-> frame_sum == scfi_pkg::RST_BYTE)
      else $error("reply sum not cleared");
   // can reply ends on the value, no checksum byte
   can_no_sum_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R13]
      (tx_valid && tx_last && can_mode) |-> tx_data == res.value[7:0])
      else $error("can reply carries a checksum byte");
endmodule : scfi_top
`default_nettype wire

/* verif/scfi_host_model.sv */
// scfi_host_model: bus master that sends command frames and gathers replies
// assumes: shares clk_sys with the interpreter; slow makes tx_ready stall
`default_nettype none
module scfi_host_model (
   input wire logic clk_sys,
   input wire logic slow,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rep[$]; // reply bytes taken
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b0;
   end
   // -----------------------------------------------------------------
   // reply side
   // -----------------------------------------------------------------
   // ready toggles every cycle when slow, to stall the transmitter
   always @(posedge clk_sys) begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
         rep.push_back(tx_data);
      end
   end
   // -----------------------------------------------------------------
   // command side
   // -----------------------------------------------------------------
   // one frame, a byte a cycle; the released line shows the inverted last byte
   task automatic send(input logic can, input logic [7:0] adr, input logic [55:0] pay,
                       input logic [7:0] bend);
      logic [7:0] b[$];
      logic [7:0] sum;
      rep.delete(); // caller waited for the previous reply
      if (!can) begin
         b.push_back(adr); // address leads serial frames
      end
      for (int i = 0; i < 7; i++) begin
         b.push_back(pay[55-8*i -: 8]); // cmd, type, bank, value msb first
      end
      sum = 8'h00;
      foreach (b[i]) sum = sum + b[i]; // carry dropped
      if (!can) begin
         b.push_back(sum + bend); // no address or sum on can
      end
      foreach (b[i]) begin
         @(posedge clk_sys);
         rx_valid <= 1'b1;
         rx_data <= b[i];
      end
      @(posedge clk_sys);
      rx_valid <= 1'b0;
      rx_data <= ~b[b.size()-1];
   endtask : send
endmodule : scfi_host_model
`default_nettype wire

/* verif/tb_top.sv */
// tb_top: self-checking bench for the command frame interpreter
// assumes: scfi_pkg and scfi_top compiled first; bench plays the executor
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, rst_n = 1'b0, can_mode = 1'b0, exec_done = 1'b0, slow = 1'b0;
   logic [7:0] module_addr = 8'h01, reply_addr = 8'h02; // own and host address
   scfi_pkg::scfi_res_s exec_res = '0;
   scfi_pkg::scfi_cmd_s exec_cmd;
   logic rx_valid, tx_ready, tx_valid, tx_last, drive_en, exec_start;
   logic [7:0] rx_data, tx_data;
   int num_errors = 0, samples_checked = 0, cycles = 0, n_start, n_last;
   logic drive_seen;
   always #5 clk_sys = ~clk_sys;
   scfi_top i_scfi_top (.clk_sys(clk_sys), .rst_n(rst_n), .can_mode(can_mode),
      .module_addr(module_addr), .reply_addr(reply_addr), .rx_valid(rx_valid),
      .rx_data(rx_data), .tx_ready(tx_ready), .exec_done(exec_done), .exec_res(exec_res),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .drive_en(drive_en),
      .exec_start(exec_start), .exec_cmd(exec_cmd));
   scfi_host_model i_scfi_host_model (.clk_sys(clk_sys), .slow(slow), .tx_valid(tx_valid),
      .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready));
   // -----------------------------------------------------------------
   // monitors and timeout
   // -----------------------------------------------------------------
   // count command hand-overs, final bytes and any transmit phase
   always @(posedge clk_sys) begin
      cycles++;
      if (exec_start === 1'b1) n_start++;
      if (tx_valid === 1'b1 && tx_ready && tx_last === 1'b1) n_last++;
      if (drive_en === 1'b1) drive_seen = 1'b1;
      if (cycles == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   // -----------------------------------------------------------------
   // shared transaction
   // -----------------------------------------------------------------
   // send one frame, act as executor if handed over, then judge the reply
   task automatic transact(input logic can, input logic [7:0] adr, input logic [7:0] bend,
                           input logic [7:0] st, input logic [31:0] val, input int exp_n);
      logic [7:0] exp[$];
      logic [7:0] s;
      int k;
      n_start = 0;
      n_last = 0;
      drive_seen = 1'b0;
      i_scfi_host_model.send(can, adr, {8'h05, 8'h04, 8'h03, val}, bend);
      repeat (3) @(negedge clk_sys);
      if (st != scfi_pkg::ST_BAD_SUM && exp_n != 0) begin
         `CHK(n_start, 1)
         `CHK(exec_cmd, {8'h05, 8'h04, 8'h03, val})
         repeat (5) @(negedge clk_sys);
         `CHK(drive_seen, 1'b0)
         @(posedge clk_sys);
         exec_done <= 1'b1;
         exec_res <= {st, val};
         @(posedge clk_sys);
         exec_done <= 1'b0;
      end
      k = 0;
      while (k < 300 && !(i_scfi_host_model.rep.size() >= exp_n && drive_en === 1'b0)) begin
         @(negedge clk_sys);
         k++;
      end
      repeat (30) @(negedge clk_sys);
      if (!can) begin
         exp.push_back(reply_addr);
      end
      exp.push_back(module_addr);
      exp.push_back(st);
      exp.push_back(8'h05);
      for (int i = 3; i >= 0; i--) exp.push_back(val[8*i +: 8]);
      s = 8'h00;
      foreach (exp[i]) s = s + exp[i];
      if (!can) exp.push_back(s); // no checksum byte on can
      `CHK(i_scfi_host_model.rep.size(), exp_n)
      `CHK(n_last, (exp_n != 0) ? 1 : 0)
      `CHK(drive_seen, exp_n != 0)
      `CHK(drive_en, 1'b0)
      if (exp_n != 0 && i_scfi_host_model.rep.size() == exp_n) begin
         foreach (exp[i]) `CHK(i_scfi_host_model.rep[i], exp[i])
      end
      if (exp_n == 0 || st == scfi_pkg::ST_BAD_SUM) `CHK(n_start, 0)
   endtask : transact
   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   // every executor status is echoed back to the host
   task automatic sc_status_codes();
      logic [7:0] codes[7] = '{scfi_pkg::ST_OK, scfi_pkg::ST_STORED, scfi_pkg::ST_BAD_CMD,
         scfi_pkg::ST_BAD_TYPE, scfi_pkg::ST_BAD_VALUE, scfi_pkg::ST_LOCKED,
         scfi_pkg::ST_UNAVAIL};
      foreach (codes[i]) transact(1'b0, 8'h01, 8'h00, codes[i], 32'h1234_5678, 9);
   endtask : sc_status_codes
   // corrupted checksum answered with status one, no hand-over
   task automatic sc_bad_sum();
      transact(1'b0, 8'h01, 8'h01, scfi_pkg::ST_BAD_SUM, 32'h0000_0000, 9);
   endtask : sc_bad_sum
   // frame for another module stays unanswered
   task automatic sc_foreign();
      transact(1'b0, 8'h5b, 8'h00, scfi_pkg::ST_OK, 32'h0000_0001, 0);
   endtask : sc_foreign
   // seven-byte frames and replies on can
   task automatic sc_can();
      @(posedge clk_sys);
      can_mode <= 1'b1;
      transact(1'b1, 8'h00, 8'h00, scfi_pkg::ST_OK, 32'hfedc_ba98, 7);
      @(posedge clk_sys);
      can_mode <= 1'b0;
   endtask : sc_can
   // stalling host, value that carries in the sum
   task automatic sc_slow();
      @(posedge clk_sys);
      slow <= 1'b1;
      transact(1'b0, 8'h01, 8'h00, scfi_pkg::ST_OK, 32'hff80_ffff, 9);
      @(posedge clk_sys);
      slow <= 1'b0;
   endtask : sc_slow
   // -----------------------------------------------------------------
   // verdict
   // -----------------------------------------------------------------
   task automatic tally_and_finish();
      $display("errors %0d, comparisons %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish
   // main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      sc_status_codes();
      sc_bad_sum();
      sc_foreign();
      sc_can();
      sc_slow();
      sc_status_codes();
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
